// File: rtl/bcr_params.svh
// Offsets, field positions and reset values of the boost configuration registers.
// Assumes inclusion by bare name from files under rtl/.
`ifndef BCR_PARAMS_SVH
`define BCR_PARAMS_SVH
// Offsets of switching_rate_sel_voltage_cfg, boost_drive_limit_cfg, boost_max_jump_cfg and the aux byte
`define BCR_OFS_FREQ_VOLT 8'ha6
`define BCR_OFS_DRIVE_LIM 8'ha7
`define BCR_OFS_MAX_JUMP 8'ha9
`define BCR_OFS_AUX 8'haa
`define BCR_RST_FREQ_VOLT 8'h00
`define BCR_RST_DRIVE_LIM 8'h00
`define BCR_RST_MAX_JUMP 8'h00
`define BCR_RST_AUX 8'h00
`define BCR_MASK_FREQ_VOLT 8'hff
`define BCR_MASK_DRIVE_LIM 8'h33
`define BCR_MASK_MAX_JUMP 8'hff
`define BCR_MASK_AUX 8'h08
`define BCR_BIT_ADAPTIVE 3
`define BCR_BIT_STAGE_C 5
`define BCR_BIT_STAGE_B 4
`define BCR_BIT_JUMP_EN 4
`endif

// File: rtl/bcr_pkg.sv
// Types shared by the boost configuration register bank.
// Assumes nothing of its surroundings.
package bcr_pkg;
  typedef enum logic [1:0] {
    BCR_RATE_312K,
    BCR_RATE_625K,
    BCR_RATE_1250K,
    BCR_RATE_UNDEF
  } bcr_rate_type;
  typedef logic [7:0] bcr_byte_type;
endpackage : bcr_pkg

// File: rtl/bcr_reg_if.sv
// Register write/read carrier between the top and the storage module.
// Assumes a single clock domain.
`timescale 1ns/100ps
`default_nettype none
interface bcr_reg_if;
  logic [3:0] wr_sel;
  logic [7:0] wr_data;
  logic [7:0] q [4];
  modport host (output wr_sel, output wr_data, input q);
  modport store (input wr_sel, input wr_data, output q);
endinterface : bcr_reg_if
`default_nettype wire

// File: rtl/bcr_reg_store.sv
// Storage for the four configuration bytes, one generate entry each.
// Assumes one-hot write selects from the decoding top.
`timescale 1ns/100ps
`default_nettype none
`include "bcr_params.svh"
module bcr_reg_store
  import bcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  bcr_reg_if.store rif
);
  localparam bcr_byte_type RST [4] = '{`BCR_RST_FREQ_VOLT, `BCR_RST_DRIVE_LIM,
    `BCR_RST_MAX_JUMP, `BCR_RST_AUX};
  localparam bcr_byte_type MASK [4] = '{`BCR_MASK_FREQ_VOLT, `BCR_MASK_DRIVE_LIM,
    `BCR_MASK_MAX_JUMP, `BCR_MASK_AUX};
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_reg
      logic [7:0] val_ff;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          val_ff <= RST[i];
        end else if (rif.wr_sel[i]) begin
          // Reserved bits are dropped so they always read back as zero
          val_ff <= rif.wr_data & MASK[i];
        end
      end
      assign rif.q[i] = val_ff;
    end
  endgenerate
endmodule : bcr_reg_store
`default_nettype wire

// File: rtl/bcr_top.sv
// Boost converter and jump detection configuration register bank.
// Assumes a synchronous host port and an analogue converter reading the decoded outputs.
`timescale 1ns/100ps
`default_nettype none
`include "bcr_params.svh"
// Overview of operation
// - With the external rate-set enable low, the two-bit rate field picks 312, 625 or 1250 kHz.
// - A six-bit output voltage setting in bits 5:0 of the first register sets the boost voltage.
// - With adaptive control on, the voltage setting is both the floor and the start voltage.
// - Bits 5 and 4 each enable an extra gate-driver stage, setting drive strength and slew rate.
// - The current-limit field with the doubling bit picks the inductor current limit.
// - The ceiling field in bits 7:5 with the range bit selects the maximum boost voltage.
// - Bit 4 enables jump detection on the PWM input with a two-bit threshold field.
// - A two-bit jump voltage field picks 0.5, 1, 2 or 4 V.
// - The adaptive enable sits in bit 3 of a neighbouring register.
module bcr_top
  import bcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic external_rate_set_enable,
  input wire logic current_limit_doubling,
  input wire logic voltage_ceiling_range,
  output logic [7:0] rdata,
  output logic rate_ext_sel,
  output bcr_rate_type switching_rate_sel,
  output logic [5:0] output_voltage_setting,
  output logic adaptive_enable,
  output logic [5:0] voltage_floor,
  output logic gate_stage_c_enable,
  output logic gate_stage_b_enable,
  output logic [1:0] inductor_current_limit_sel,
  output logic limit_code_illegal,
  output logic [2:0] voltage_ceiling_sel,
  output logic ceiling_code_illegal,
  output logic jump_detect_enable,
  output logic [1:0] jump_threshold_sel,
  output logic [1:0] jump_voltage_sel
);
  bcr_reg_if rif ();
  logic [7:0] rdata_ff;
  logic rate_ext_ff;
  bcr_rate_type rate_ff;
  logic [5:0] volt_ff;
  logic adapt_ff;
  logic [5:0] floor_ff;
  logic stage_c_ff;
  logic stage_b_ff;
  logic [1:0] ilim_ff;
  logic ilim_bad_ff;
  logic [2:0] ceil_ff;
  logic ceil_bad_ff;
  logic jump_en_ff;
  logic [1:0] jump_th_ff;
  logic [1:0] jump_v_ff;
  logic [7:0] nxt_rdata;

  bcr_reg_store u_store (
    .clk(clk),
    .reset(reset),
    .rif(rif)
  );

  always_comb begin
    rif.wr_sel = 4'h0;
    rif.wr_data = wdata;
    if (wr_en) begin
      rif.wr_sel[0] = (addr == `BCR_OFS_FREQ_VOLT);
      rif.wr_sel[1] = (addr == `BCR_OFS_DRIVE_LIM);
      rif.wr_sel[2] = (addr == `BCR_OFS_MAX_JUMP);
      rif.wr_sel[3] = (addr == `BCR_OFS_AUX);
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    unique case (addr)
      `BCR_OFS_FREQ_VOLT: nxt_rdata = rif.q[0];
      `BCR_OFS_DRIVE_LIM: nxt_rdata = rif.q[1];
      `BCR_OFS_MAX_JUMP: nxt_rdata = rif.q[2];
      `BCR_OFS_AUX: nxt_rdata = rif.q[3];
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data holds only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (rd_en) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // Rate field is passed on whatever the external resistor path; its enable is only registered beside it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rate_ext_ff <= 1'b0;
    end else begin
      rate_ext_ff <= external_rate_set_enable;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rate_ff <= BCR_RATE_312K;
    end else begin
      rate_ff <= bcr_rate_type'(rif.q[0][7:6]);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      volt_ff <= 6'h00;
    end else begin
      volt_ff <= rif.q[0][5:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      adapt_ff <= 1'b0;
    end else begin
      adapt_ff <= rif.q[3][`BCR_BIT_ADAPTIVE];
    end
  end

  // In fixed mode no floor applies, so it reads zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      floor_ff <= 6'h00;
    end else begin
      floor_ff <= rif.q[3][`BCR_BIT_ADAPTIVE] ? rif.q[0][5:0] : 6'h00;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage_c_ff <= 1'b0;
    end else begin
      stage_c_ff <= rif.q[1][`BCR_BIT_STAGE_C];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage_b_ff <= 1'b0;
    end else begin
      stage_b_ff <= rif.q[1][`BCR_BIT_STAGE_B];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ilim_ff <= 2'h0;
    end else begin
      ilim_ff <= rif.q[1][1:0];
    end
  end

  // Flagged, not corrected: the converter decides how to clamp
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ilim_bad_ff <= 1'b0;
    end else begin
      ilim_bad_ff <= current_limit_doubling && (rif.q[1][1:0] == 2'h3);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ceil_ff <= 3'h0;
    end else begin
      ceil_ff <= rif.q[2][7:5];
    end
  end

  // Codes below 010 have no ceiling at all, so they are flagged in both ranges
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ceil_bad_ff <= 1'b0;
    end else begin
      ceil_bad_ff <= (rif.q[2][7] == 1'b0)
        && !(voltage_ceiling_range && (rif.q[2][6] == 1'b1));
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      jump_en_ff <= 1'b0;
    end else begin
      jump_en_ff <= rif.q[2][`BCR_BIT_JUMP_EN];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      jump_th_ff <= 2'h0;
    end else begin
      jump_th_ff <= rif.q[2][3:2];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      jump_v_ff <= 2'h0;
    end else begin
      jump_v_ff <= rif.q[2][1:0];
    end
  end

  assign rdata = rdata_ff;
  assign rate_ext_sel = rate_ext_ff;
  assign switching_rate_sel = rate_ff;
  assign output_voltage_setting = volt_ff;
  assign adaptive_enable = adapt_ff;
  assign voltage_floor = floor_ff;
  assign gate_stage_c_enable = stage_c_ff;
  assign gate_stage_b_enable = stage_b_ff;
  assign inductor_current_limit_sel = ilim_ff;
  assign limit_code_illegal = ilim_bad_ff;
  assign voltage_ceiling_sel = ceil_ff;
  assign ceiling_code_illegal = ceil_bad_ff;
  assign jump_detect_enable = jump_en_ff;
  assign jump_threshold_sel = jump_th_ff;
  assign jump_voltage_sel = jump_v_ff;
endmodule : bcr_top
`default_nettype wire

// File: bench/bcr_props.sv
// Concurrent checks on the register bank ports.
// Assumes binding to bcr_top with one clock.
`timescale 1ns/100ps
`default_nettype none
module bcr_props
  import bcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire bcr_rate_type switching_rate_sel,
  input wire logic [5:0] output_voltage_setting,
  input wire logic adaptive_enable,
  input wire logic [5:0] voltage_floor,
  input wire logic gate_stage_c_enable,
  input wire logic gate_stage_b_enable,
  input wire logic [1:0] inductor_current_limit_sel,
  input wire logic [2:0] voltage_ceiling_sel,
  input wire logic jump_detect_enable,
  input wire logic [1:0] jump_threshold_sel,
  input wire logic [1:0] jump_voltage_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_wr(logic [7:0] a);
    wr_en && addr == a;
  endsequence
  // Decoded outputs lag the register by one edge
  sequence s_quiet;
    !wr_en ##1 !wr_en;
  endsequence
  a_rate_follow: assert property (s_wr(8'ha6) |-> ##2 switching_rate_sel == $past(wdata[7:6], 2))
    else $error("rate select stale");
  a_volt_follow: assert property (s_wr(8'ha6) |-> ##2 output_voltage_setting == $past(wdata[5:0], 2))
    else $error("voltage setting stale");
  a_floor_track: assert property (voltage_floor == (adaptive_enable ? output_voltage_setting : 6'h00))
    else $error("floor wrong");
  a_drive_follow: assert property (s_wr(8'ha7) |-> ##2 {gate_stage_c_enable, gate_stage_b_enable,
    inductor_current_limit_sel} == {$past(wdata[5:4], 2), $past(wdata[1:0], 2)}) else $error("drive stale");
  a_ceil_jump: assert property (s_wr(8'ha9) |-> ##2 {voltage_ceiling_sel, jump_detect_enable,
    jump_threshold_sel, jump_voltage_sel} == $past(wdata, 2)) else $error("ceiling or jump stale");
  a_adapt_bit: assert property (s_wr(8'haa) |-> ##2 adaptive_enable == $past(wdata[3], 2))
    else $error("adaptive stale");
  a_volt_hold: assert property (s_quiet |=> $stable(output_voltage_setting))
    else $error("voltage moved without write");
  a_rdata_idle: assert property (!rd_en |=> rdata == 8'h00)
    else $error("rdata not idle");
endmodule : bcr_props
bind bcr_top bcr_props bcr_props_u (.*);
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench of the boost configuration register bank.
// Assumes design files and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb
  import bcr_pkg::*;
;
  logic clk = 0, reset = 1, wr_en = 0, rd_en = 0, external_rate_set_enable = 0;
  logic current_limit_doubling = 0, voltage_ceiling_range = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic rate_ext_sel, adaptive_enable, gate_stage_c_enable, gate_stage_b_enable;
  logic limit_code_illegal, ceiling_code_illegal, jump_detect_enable;
  bcr_rate_type switching_rate_sel;
  logic [5:0] output_voltage_setting, voltage_floor;
  logic [1:0] inductor_current_limit_sel, jump_threshold_sel, jump_voltage_sel;
  logic [2:0] voltage_ceiling_sel;
  logic [7:0] sh [5] = '{default: 8'h00};
  logic [7:0] regs [5] = '{8'ha6, 8'ha7, 8'ha9, 8'haa, 8'ha8};
  int error_cnt = 0, n_tests = 0, cycles = 0, seed;
  bcr_top dut_u (.*);
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Reserved bits must vanish; index 4 is unmapped
  function automatic logic [7:0] mask(input int i);
    return i == 1 ? 8'h33 : i == 3 ? 8'h08 : i == 4 ? 8'h00 : 8'hff;
  endfunction : mask
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input int i, input logic [7:0] d);
    @(posedge clk);
    addr <= regs[i];
    wdata <= d;
    wr_en <= 1'b1;
    sh[i] = d & mask(i);
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input int i);
    @(posedge clk);
    addr <= regs[i];
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 check("rdata", rdata, sh[i]);
  endtask : rd
  task automatic dec;
    repeat (2) @(posedge clk);
    #1 check("rate", switching_rate_sel, sh[0][7:6]);
    check("volt", output_voltage_setting, sh[0][5:0]);
    check("floor", voltage_floor, sh[3][3] ? sh[0][5:0] : 6'h00);
    check("adapt", adaptive_enable, sh[3][3]);
    check("drive", {gate_stage_c_enable, gate_stage_b_enable}, sh[1][5:4]);
    check("limit", inductor_current_limit_sel, sh[1][1:0]);
    check("lim bad", limit_code_illegal, current_limit_doubling && &sh[1][1:0]);
    check("ceil", voltage_ceiling_sel, sh[2][7:5]);
    check("ceil bad", ceiling_code_illegal, !sh[2][7] && !(sh[2][6] && voltage_ceiling_range));
    check("jump", {jump_detect_enable, jump_threshold_sel, jump_voltage_sel}, sh[2][4:0]);
    check("ext", rate_ext_sel, external_rate_set_enable);
  endtask : dec
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    seed = 62236;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) rd(i);
    current_limit_doubling <= 1'b1;
    for (int i = 0; i < 5; i++) wr(i, 8'hff);
    wr(2, 8'h5f);
    dec();
    for (int i = 0; i < 5; i++) rd(i);
    for (int k = 0; k < 80; k++) begin
      @(posedge clk);
      external_rate_set_enable <= 1'($random(seed));
      current_limit_doubling <= 1'($random(seed));
      voltage_ceiling_range <= 1'($random(seed));
      wr(k % 5, 8'($random(seed)));
      dec();
      rd(k % 5);
    end
    // Mid-run reset must bring every register and decoded field back to zero; ceiling code 000 is then flagged illegal
    @(posedge clk);
    reset <= 1'b1;
    sh = '{default: 8'h00};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    dec();
    for (int i = 0; i < 5; i++) rd(i);
    conclude();
  end
endmodule : tb
`default_nettype wire
